// ---- hw/msr_defines.svh ----
// Constants of the master/slave resolution block: offsets, fields, counts.
// Assumes inclusion by bare name from the package and design modules.
`ifndef MSR_DEFINES_SVH
`define MSR_DEFINES_SVH
// Register byte offsets
`define MSR_AW           8
`define MSR_OFF_CTRL     8'h00
`define MSR_OFF_STAT     8'h04
`define MSR_OFF_ISTAT    8'h08
`define MSR_OFF_IMASK    8'h0C
// Control fields
`define MSR_C_MAN_EN     0
`define MSR_C_MAN_MST    1
`define MSR_C_MULTI      2
`define MSR_C_RESTART    3
// Status fields
`define MSR_S_DONE       0
`define MSR_S_MASTER     1
`define MSR_S_CNT_LO     2
`define MSR_S_FAULT      15
// Interrupt status and mask fields
`define MSR_I_DONE       0
`define MSR_I_FAULT      1
// Page contents
`define MSR_PW           16
`define MSR_MSG_CODE     11'h001
`define MSR_P_MAN_EN     0
`define MSR_P_MAN_MST    1
`define MSR_P_MULTI      2
// Seed and attempt limits
`define MSR_SEED_W       11
`define MSR_SEED_INIT    11'h5A5
`define MSR_MAX_SEEDS    3'h7
// Bus responses
`define MSR_RESP_OKAY    2'h0
`define MSR_RESP_SLVERR  2'h2
`endif

// ---- hw/msr_pkg.sv ----
// Types of the master/slave resolution block.
// Assumes msr_defines.svh on the include path.
`include "msr_defines.svh"
package msr_pkg;
  typedef enum logic [7:0] {
    MSR_IDLE  = 8'h01,
    MSR_BASE  = 8'h02,
    MSR_FNP   = 8'h04,
    MSR_UNP1  = 8'h08,
    MSR_UNP2  = 8'h10,
    MSR_RSLV  = 8'h20,
    MSR_DONE  = 8'h40,
    MSR_FAULT = 8'h80
  } msr_state_t;

  typedef enum logic [1:0] {
    MSR_R_SLAVE  = 2'h0,
    MSR_R_MASTER = 2'h1,
    MSR_R_FAULT  = 2'h2,
    MSR_R_RETRY  = 2'h3
  } msr_res_t;
endpackage

// ---- hw/msr_seed_gen.sv ----
// Free-running seed source for the seed page.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
`include "msr_defines.svh"
module msr_seed_gen
  import msr_pkg::*;
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Seed
  output logic [`MSR_SEED_W-1:0]       seed
);
  typedef struct packed {
    logic [`MSR_SEED_W-1:0] lfsr;
  } msr_seed_st_t;

  msr_seed_st_t r;
  msr_seed_st_t n;

  // Maximal-length taps 11,9; the zero state is never reached from reset
  always_comb begin
    n = r;
    n.lfsr = {r.lfsr[`MSR_SEED_W-2:0], r.lfsr[10] ^ r.lfsr[8]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r.lfsr <= `MSR_SEED_INIT;
    end else begin
      r <= n;
    end
  end

  assign seed = r.lfsr;
endmodule
`default_nettype wire

// ---- hw/msr_axil.sv ----
// AXI4-Lite slave front end: turns bus traffic into register strobes.
// Assumes the register file answers rd_data/err combinationally.
`timescale 1ns/10ps
`default_nettype none
`include "msr_defines.svh"
module msr_axil
  import msr_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Write channels
  input  wire logic [`MSR_AW-1:0]    awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // Read channels
  input  wire logic [`MSR_AW-1:0]    araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Register side
  output logic                       wr_en,
  output logic [`MSR_AW-1:0]         wr_addr,
  output logic [31:0]                wr_data,
  output logic [3:0]                 wr_strb,
  input  wire logic                  wr_err,
  output logic                       rd_en,
  output logic [`MSR_AW-1:0]         rd_addr,
  input  wire logic [31:0]           rd_data,
  input  wire logic                  rd_err
);
  typedef struct packed {
    logic               aw_ok;
    logic [`MSR_AW-1:0] addr;
    logic               w_ok;
    logic [31:0]        data;
    logic [3:0]         strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } msr_axil_st_t;

  msr_axil_st_t r;
  msr_axil_st_t n;

  // Address and data may arrive in either order; commit once both are held
  assign awready = !r.aw_ok;
  assign wready  = !r.w_ok;
  assign wr_en   = r.aw_ok && r.w_ok && !r.bvalid;
  assign wr_addr = r.addr;
  assign wr_data = r.data;
  assign wr_strb = r.strb;
  assign arready = !r.rvalid;
  assign rd_en   = arvalid && !r.rvalid;
  assign rd_addr = araddr;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;

  // Channel bookkeeping
  always_comb begin
    n = r;
    if (awvalid && awready) begin
      n.aw_ok = 1'b1;
      n.addr  = awaddr;
    end
    if (wvalid && wready) begin
      n.w_ok = 1'b1;
      n.data = wdata;
      n.strb = wstrb;
    end
    if (wr_en) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = wr_err ? `MSR_RESP_SLVERR : `MSR_RESP_OKAY;
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (rd_en) begin
      n.rvalid = 1'b1;
      n.rdata  = rd_data;
      n.rresp  = rd_err ? `MSR_RESP_SLVERR : `MSR_RESP_OKAY;
    end else if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule
`default_nettype wire

// ---- hw/msr_core.sv ----
// Gigabit copper master/slave role resolution with AXI4-Lite registers.
// Assumes the negotiation engine pulses pg_xchg once per page exchanged,
// on aclk, with the partner's page word on pg_rx_data.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "msr_defines.svh"
module msr_core
  import msr_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write
  input  wire logic [`MSR_AW-1:0]    awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  // AXI4-Lite read
  input  wire logic [`MSR_AW-1:0]    araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  // Negotiation engine
  input  wire logic                  an_start,
  input  wire logic                  pg_xchg,
  input  wire logic [`MSR_PW-1:0]    pg_rx_data,
  output logic [`MSR_PW-1:0]         pg_tx_data,
  // Role and link
  input  wire logic                  link_ok_in,
  output logic                       cfg_complete,
  output logic                       cfg_master,
  output logic                       gigabit_copper_link_state,
  output logic                       irq
);
  typedef struct packed {
    msr_state_t              state;
    logic [2:0]              seed_cnt;
    logic                    fault;
    logic                    done;
    logic                    master;
    logic [`MSR_PW-1:0]      pg_tx;
    logic [2:0]              rx_ab;
    logic [`MSR_SEED_W-1:0]  loc_seed;
    logic [`MSR_SEED_W-1:0]  rem_seed;
    logic [2:0]              ctrl;
    logic [1:0]              istat;
    logic [1:0]              imask;
    logic                    link;
  } msr_core_st_t;

  msr_core_st_t r;
  msr_core_st_t n;

  logic                    wr_en;
  logic [`MSR_AW-1:0]      wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic [`MSR_AW-1:0]      rd_addr;
  logic [31:0]             rd_data;
  logic [`MSR_SEED_W-1:0]  seed;
  logic                    start;
  logic                    ctrl_wr;
  logic [1:0]              ev;
  msr_res_t                res;

  // Bus front end
  msr_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (!addr_hit(wr_addr)),
    .rd_en   (),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (!addr_hit(rd_addr))
  );

  // Seed source
  msr_seed_gen u_seed (
    .aclk    (aclk),
    .aresetn (aresetn),
    .seed    (seed)
  );

  // Address decode, shared by the read and write paths
  function automatic logic addr_hit(input logic [`MSR_AW-1:0] a);
    return (a == `MSR_OFF_CTRL) || (a == `MSR_OFF_STAT) ||
           (a == `MSR_OFF_ISTAT) || (a == `MSR_OFF_IMASK);
  endfunction

  // Role decision from local control and partner ability and seed
  function automatic msr_res_t resolve(input logic [2:0] loc,
                                       input logic [2:0] rem,
                                       input logic [`MSR_SEED_W-1:0] ls,
                                       input logic [`MSR_SEED_W-1:0] rs);
    logic lm;
    logic rm;
    lm = loc[`MSR_P_MAN_EN];
    rm = rem[`MSR_P_MAN_EN];
    if (lm && rm) begin
      // Equal forced roles cannot both hold
      if (loc[`MSR_P_MAN_MST] == rem[`MSR_P_MAN_MST]) begin
        return MSR_R_FAULT;
      end
      return loc[`MSR_P_MAN_MST] ? MSR_R_MASTER : MSR_R_SLAVE;
    end else if (lm) begin
      return loc[`MSR_P_MAN_MST] ? MSR_R_MASTER : MSR_R_SLAVE;
    end else if (rm) begin
      return rem[`MSR_P_MAN_MST] ? MSR_R_SLAVE : MSR_R_MASTER;
    end else if (loc[`MSR_P_MULTI] != rem[`MSR_P_MULTI]) begin
      // The multiport end prefers to be master
      return loc[`MSR_P_MULTI] ? MSR_R_MASTER : MSR_R_SLAVE;
    end else if (ls == rs) begin
      return MSR_R_RETRY;
    end
    return (ls > rs) ? MSR_R_MASTER : MSR_R_SLAVE;
  endfunction

  assign ctrl_wr = wr_en && (wr_addr == `MSR_OFF_CTRL) && wr_strb[0];
  assign start   = an_start || (ctrl_wr && wr_data[`MSR_C_RESTART]);
  assign res     = resolve(r.ctrl, r.rx_ab, r.loc_seed, r.rem_seed);

  // Register read mux; reserved bits read as zero
  always_comb begin
    rd_data = 32'h0;
    unique case (rd_addr)
      `MSR_OFF_CTRL: rd_data[2:0] = r.ctrl;
      `MSR_OFF_STAT: begin
        rd_data[`MSR_S_DONE]   = r.done;
        rd_data[`MSR_S_MASTER] = r.master;
        rd_data[`MSR_S_CNT_LO+:3] = r.seed_cnt;
        rd_data[`MSR_S_FAULT]  = r.fault;
      end
      `MSR_OFF_ISTAT: rd_data[1:0] = r.istat;
      `MSR_OFF_IMASK: rd_data[1:0] = r.imask;
      default: rd_data = 32'h0;
    endcase
  end

  // Resolution sequencer, control and interrupt registers
  always_comb begin
    n  = r;
    ev = 2'h0;
    if (ctrl_wr) begin
      n.ctrl = wr_data[2:0];
    end
    if (wr_en && (wr_addr == `MSR_OFF_IMASK) && wr_strb[0]) begin
      n.imask = wr_data[1:0];
    end
    unique case (r.state)
      MSR_IDLE, MSR_DONE, MSR_FAULT: begin
        // Settled; only a restart brings a new attempt
        n.state = r.state;
      end
      MSR_BASE: begin
        if (pg_xchg) begin
          n.state = MSR_FNP;
          n.pg_tx = {5'h00, `MSR_MSG_CODE};
        end
      end
      MSR_FNP: begin
        // A foreign message breaks the sequence
        if (pg_xchg) begin
          if (pg_rx_data[10:0] == `MSR_MSG_CODE) begin
            n.state = MSR_UNP1;
            n.pg_tx = {13'h0000, r.ctrl};
          end else begin
            n.state = MSR_IDLE;
            n.pg_tx = 16'h0000;
          end
        end
      end
      MSR_UNP1: begin
        if (pg_xchg) begin
          n.state    = MSR_UNP2;
          n.rx_ab    = pg_rx_data[2:0];
          n.loc_seed = seed;
          n.pg_tx    = {5'h00, seed};
          if (r.seed_cnt != `MSR_MAX_SEEDS) begin
            n.seed_cnt = r.seed_cnt + 3'h1;
          end
        end
      end
      MSR_UNP2: begin
        if (pg_xchg) begin
          n.state    = MSR_RSLV;
          n.rem_seed = pg_rx_data[`MSR_SEED_W-1:0];
          n.pg_tx    = 16'h0000;
        end
      end
      MSR_RSLV: begin
        if ((res == MSR_R_FAULT) ||
            ((res == MSR_R_RETRY) && (r.seed_cnt == `MSR_MAX_SEEDS))) begin
          n.state    = MSR_FAULT;
          n.fault    = 1'b1;
          n.done     = 1'b1;
          n.seed_cnt = 3'h0;
          ev[`MSR_I_FAULT] = 1'b1;
        end else if (res == MSR_R_RETRY) begin
          // Tied seeds: run the page exchange again with a fresh seed
          n.state = MSR_BASE;
        end else begin
          n.state    = MSR_DONE;
          n.master   = (res == MSR_R_MASTER);
          n.done     = 1'b1;
          n.fault    = 1'b0;
          n.seed_cnt = 3'h0;
          ev[`MSR_I_DONE] = 1'b1;
        end
      end
      default: begin
        n.state = MSR_IDLE;
      end
    endcase
    if (start) begin
      n.state    = MSR_BASE;
      n.seed_cnt = 3'h0;
      n.done     = 1'b0;
      n.pg_tx    = 16'h0000;
    end
    // Write one to clear; a new event in the same cycle wins
    n.istat = r.istat & ~((wr_en && (wr_addr == `MSR_OFF_ISTAT) && wr_strb[0]) ?
                          wr_data[1:0] : 2'h0);
    n.istat = n.istat | ev;
    n.link  = link_ok_in && n.done && !n.fault;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r       <= '0;
      r.state <= MSR_IDLE;
    end else begin
      r <= n;
    end
  end

  assign pg_tx_data                = r.pg_tx;
  assign cfg_complete              = r.done;
  assign cfg_master                = r.master;
  assign gigabit_copper_link_state = r.link;
  assign irq                       = |(r.istat & r.imask);

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_fnp_ok;
    (r.state == MSR_FNP) && pg_xchg && (pg_rx_data[10:0] == `MSR_MSG_CODE) && !start;
  endsequence
  sequence s_in_unp1;
    ##1 (r.state == MSR_UNP1);
  endsequence
  sequence s_tie_last;
    (r.state == MSR_RSLV) && (res == MSR_R_RETRY) &&
    (r.seed_cnt == `MSR_MAX_SEEDS) && !start;
  endsequence

  AST_PAGE_ORDER: assert property (s_fnp_ok |-> s_in_unp1)
    else $error("formatted page did not lead to ability page");
  AST_CNT_START: assert property (start |=> (r.seed_cnt == 3'h0) && (r.state == MSR_BASE))
    else $error("restart did not clear seed count");
  AST_CNT_INC: assert property ((r.state == MSR_UNP1) && pg_xchg && !start &&
      (r.seed_cnt < `MSR_MAX_SEEDS) |=> r.seed_cnt == $past(r.seed_cnt) + 3'h1)
    else $error("seed count did not advance on new seed");
  AST_DONE_CLR: assert property ($rose(r.state == MSR_DONE) |->
      (r.seed_cnt == 3'h0) && !r.fault && r.done)
    else $error("completion left count or fault set");
  AST_SEVEN: assert property (s_tie_last |=> (r.state == MSR_FAULT) && r.fault)
    else $error("seventh tie did not fault");
  AST_HIGH_MASTER: assert property ((r.state == MSR_RSLV) && !start && !r.ctrl[0] &&
      !r.rx_ab[0] && (r.ctrl[2] == r.rx_ab[2]) && (r.loc_seed > r.rem_seed)
      |=> (r.state == MSR_DONE) && cfg_master)
    else $error("higher seed did not become master");
  AST_SAME_FORCED: assert property ((r.state == MSR_RSLV) && !start && r.ctrl[0] &&
      r.rx_ab[0] && (r.ctrl[1] == r.rx_ab[1]) |=> r.fault ##1 r.fault)
    else $error("equal forced roles did not fault");
  AST_FAULT_DONE: assert property ($rose(r.state == MSR_FAULT) |-> r.fault && cfg_complete)
    else $error("fault not flagged as complete");
  AST_LINK_FAIL: assert property (r.fault |-> !gigabit_copper_link_state)
    else $error("link state not failed under fault");
  AST_NO_RETRY: assert property ((r.state == MSR_FAULT) && !start [*2] |->
      (r.state == MSR_FAULT) && $stable(r.seed_cnt))
    else $error("seed attempt after fault without restart");
endmodule
`default_nettype wire

// ---- bench/msr_partner.sv ----
// Link partner model: plays the far end of the page exchange.
// Assumes the core samples pg_xchg on aclk and shows its next page on pg_tx_data.
`timescale 1ns/10ps
`default_nettype none
`include "msr_defines.svh"
module msr_partner
  import msr_pkg::*;
(
  // Clock
  input  wire logic               aclk,
  // Page link
  input  wire logic [`MSR_PW-1:0] pg_tx_data,
  output logic                    an_start,
  output logic                    pg_xchg,
  output logic [`MSR_PW-1:0]      pg_rx_data
);
  // Page word the core offered at each exchange of the last round
  logic [15:0] seen [0:3];

  // Quiet link at time zero
  initial begin
    an_start   = 1'b0;
    pg_xchg    = 1'b0;
    pg_rx_data = 16'h0000;
  end

  // Optional start, then whole rounds; mode 0 higher seed, 1 lower, 2 equal
  task automatic run(input bit st, input int rounds, input logic [1:0] mode,
                     input logic [2:0] abil, input logic [10:0] code);
    logic [15:0] pg;
    if (st) begin
      @(posedge aclk);
      an_start <= 1'b1;
      @(posedge aclk);
      an_start <= 1'b0;
    end
    repeat (rounds) begin
      // Base, formatted, two unformatted, no gaps filled by others
      for (int p = 0; p < 4; p++) begin
        repeat (3) @(posedge aclk);
        case (p)
          0: pg = 16'h0000;
          1: pg = {5'h00, code};
          2: pg = {13'h0000, abil}; // Manual role and port type
          default: pg = {5'h00, (mode == 2'h0) ? 11'h7FF :
                                (mode == 2'h1) ? 11'h000 : pg_tx_data[10:0]};
        endcase
        pg_xchg    <= 1'b1;
        pg_rx_data <= pg;
        @(posedge aclk);
        seen[p] = pg_tx_data;
        pg_xchg    <= 1'b0;
        pg_rx_data <= ~pg; // Stale word must not look valid
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/master_slave_resolution_bench.sv ----
// Bench of the role resolver: register traffic, page rounds, verdict.
// Assumes msr_partner drives the page link of the core.
`timescale 1ns/10ps
`default_nettype none
module master_slave_resolution_bench
  import msr_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, link_ok_in;
  logic        awready, wready, bvalid, arready, rvalid, an_start, pg_xchg;
  logic        cfg_complete, cfg_master, gigabit_copper_link_state, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, msk;
  logic [15:0] pg_rx_data, pg_tx_data;
  int          miscompares = 0;
  int          n_tests = 0;

  msr_core u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .an_start(an_start), .pg_xchg(pg_xchg), .pg_rx_data(pg_rx_data),
    .pg_tx_data(pg_tx_data), .link_ok_in(link_ok_in), .cfg_complete(cfg_complete),
    .cfg_master(cfg_master), .gigabit_copper_link_state(gigabit_copper_link_state),
    .irq(irq));
  msr_partner u_partner (.aclk(aclk), .pg_tx_data(pg_tx_data), .an_start(an_start),
    .pg_xchg(pg_xchg), .pg_rx_data(pg_rx_data));

  // Verdict, reached from the main flow and from any expired wait
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tmo();
    miscompares++;
    end_of_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) tmo();
    chk({30'h0, bresp}, {30'h0, er}); // response code
  endtask

  // Read: word lands in rd
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (rvalid !== 1'b1) tmo();
    rd = rdata;
    chk({30'h0, rresp}, {30'h0, er}); // response code
  endtask

  // Register map, access kinds, idle after reset
  task automatic s_regs();
    chk({31'h0, cfg_complete}, 32'h0); // idle after reset
    axr(8'h04, 2'h0);
    chk(rd, 32'h0); // status clear, no seeds
    axr(8'h08, 2'h0);
    chk(rd, 32'h0); // no events
    axw(8'h00, 32'h0000_000F, 2'h0);
    axr(8'h00, 2'h0);
    chk(rd, 32'h0000_0007); // restart reads back zero
    axw(8'h04, 32'h0000_FFFF, 2'h0);
    axr(8'h04, 2'h0);
    chk(rd, 32'h0); // status is read-only
    axw(8'h10, 32'h0000_0001, 2'h2);
    axr(8'h10, 2'h2);
    chk(rd, 32'h0); // unmapped reads zero
  endtask

  // One negotiation; ctl and abil are {multiport, master, manual}
  task automatic s_case(input logic [2:0] ctl, input logic [1:0] mode,
                        input logic [2:0] abil, input logic m, input logic flt);
    axw(8'h00, {29'h0, ctl}, 2'h0);
    u_partner.run(1'b1, 1, mode, abil, 11'h001);
    cyc(6);
    chk({16'h0, u_partner.seen[0]}, 32'h0); // base page word
    chk({16'h0, u_partner.seen[1]}, 32'h0000_0001); // formatted page code
    chk({16'h0, u_partner.seen[2]}, {29'h0, ctl}); // local abilities sent
    chk({31'h0, cfg_complete}, 32'h1); // done either way
    chk({31'h0, gigabit_copper_link_state}, {31'h0, ~flt}); // link state
    chk({31'h0, irq}, {31'h0, flt ? msk[1] : msk[0]}); // masked interrupt
    axr(8'h04, 2'h0);
    if (flt) chk(rd & 32'hFFFF_FFFD, 32'h0000_8001); // fault bit
    else chk(rd, {30'h0, m, 1'b1}); // role, count and fault cleared
    if (!flt) chk({31'h0, cfg_master}, {31'h0, m}); // role output
    axr(8'h08, 2'h0);
    chk(rd, flt ? 32'h2 : 32'h1); // event latched
    axw(8'h08, 32'h3, 2'h0);
    chk({31'h0, irq}, 32'h0); // cleared by writing ones
  endtask

  // Equal seeds: count, then give up at seven
  task automatic s_retry();
    axw(8'h00, 32'h0, 2'h0);
    u_partner.run(1'b1, 6, 2'h2, 3'h0, 11'h001);
    cyc(6);
    axr(8'h04, 2'h0);
    chk(rd & 32'hFFFF_FFFD, 32'h0000_0018); // six seeds sent, undecided
    u_partner.run(1'b0, 1, 2'h2, 3'h0, 11'h001);
    cyc(6);
    axr(8'h04, 2'h0);
    chk(rd & 32'hFFFF_FFFD, 32'h0000_8001); // seventh seed ends in fault
    chk({31'h0, gigabit_copper_link_state}, 32'h0); // link forced down
    axw(8'h08, 32'h3, 2'h0);
    u_partner.run(1'b0, 1, 2'h0, 3'h0, 11'h001);
    cyc(6);
    axr(8'h04, 2'h0);
    chk(rd & 32'hFFFF_FFFD, 32'h0000_8001); // pages without start ignored
    axr(8'h08, 2'h0);
    chk(rd, 32'h0); // no new result
  endtask

  // Wrong formatted page code aborts the sequence
  task automatic s_bad();
    axw(8'h00, 32'h0000_0008, 2'h0);
    u_partner.run(1'b0, 1, 2'h0, 3'h0, 11'h002);
    cyc(6);
    axr(8'h04, 2'h0);
    chk(rd & 32'hFFFF_FFFD, 32'h0000_8000); // not done, no seed; fault bit of the earlier attempt still set
    chk({31'h0, cfg_complete}, 32'h0); // still open
  endtask

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Main flow
  initial begin
    aresetn    = 1'b0;
    awvalid    = 1'b0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    awaddr     = 8'h00;
    araddr     = 8'h00;
    wdata      = 32'h0;
    wstrb      = 4'h0;
    link_ok_in = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    s_regs();
    msk = 2'h3;
    axw(8'h0C, 32'h3, 2'h0);
    s_case(3'h0, 2'h0, 3'h0, 1'b0, 1'b0); // partner seed higher
    s_case(3'h0, 2'h1, 3'h0, 1'b1, 1'b0); // partner seed lower
    s_case(3'h3, 2'h0, 3'h3, 1'b0, 1'b1); // both forced master
    msk = 2'h1;
    axw(8'h0C, 32'h1, 2'h0);
    s_case(3'h1, 2'h0, 3'h1, 1'b0, 1'b1); // both forced slave
    msk = 2'h3;
    axw(8'h0C, 32'h3, 2'h0);
    s_case(3'h3, 2'h0, 3'h0, 1'b1, 1'b0); // local force wins
    s_case(3'h0, 2'h1, 3'h3, 1'b0, 1'b0); // partner force wins
    s_case(3'h4, 2'h0, 3'h0, 1'b1, 1'b0); // multiport side leads
    link_ok_in <= 1'b0;
    cyc(2);
    chk({31'h0, gigabit_copper_link_state}, 32'h0); // monitor failure drops link
    link_ok_in <= 1'b1;
    s_retry();
    s_bad();
    end_of_test();
  end
endmodule
`default_nettype wire
